// [core/axlr_link_ctrl.sv]
// Link teardown, reset and frame-reject controller for a packet link.
// Assumes a deframer delivering decoded frames on this clock and a
// framer that takes one frame request at a time with a ready handshake.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "axlr_params.svh"

// What this block does
// - Disconnect: send DISC, retry on T1, give up to disconnected after N2.
// - DISC received while connected: answer UA, go disconnected.
// - Disconnected: may connect; incoming SABM accepted or refused with DM.
// - DISC received while disconnected is answered with DM.
// - Disconnected: polled command other than SABM or UI gets DM final.
// - Error recovery: DM with T1 retries, then stay silent disconnected.
// - Reset by SABM in transfer or frame reject state; answer UA, zero sequence and busy.
// - DM sent to request reset moves us to disconnected once sent.
// - After FRMR hold reject state; other commands repeat same FRMR.
// - FRMR retried on T1; after N2 tries the link is reset.
// - Unknown frame or oversize info field in transfer resets link.
// - DM or FRMR response in transfer always starts reset.
// - UA or unsolicited final response may optionally start reset.
// - Same unnumbered commands collide: send UA, enter requested state.
// - Different unnumbered commands collide: go disconnected, send DM.
// - Unsolicited DM has final clear; SABM and DISC carry poll set.
// - T1 configurable, meant to exceed twice a long-frame round trip.
// - T2 runs only while T1 idle; expiry sends polling supervisory frame.
// - Retry limit N2 configurable, default sixteen.
// - Info field at most 256 octets.
// - At most seven frames outstanding; smaller window by agreement.
// - Send and receive state variables count modulo 8.
module axlr_link_ctrl #(
	parameter int TICK_CYCLES = `AXLR_TICK_NS / `AXLR_CLK_NS
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Received frames
	input wire axlr_pkg::axlr_rx_type rx_frame,
	// Frame requests to the framer
	output logic tx_valid,
	output axlr_pkg::axlr_tx_type tx_frame,
	input wire logic tx_ready,
	// Sequence and flow state shared with the transfer logic
	input wire logic seq_send_inc,
	input wire logic seq_recv_inc,
	input wire logic [2:0] ack_nr,
	input wire logic busy_set,
	input wire logic busy_clr,
	output logic [2:0] seq_send,
	output logic [2:0] seq_recv,
	output logic local_busy,
	output logic window_full,
	output logic link_up
);
	import axlr_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	axlr_state_type st_q, st_d;
	axlr_tx_type tx_q, q_frame;
	logic tx_valid_q, need_t1_q, q_en, q_t1, r_clr, r_inc, seq_zero;
	logic accept_q, ua_reset_q;
	logic [15:0] t1_q, t2_q, t1_cnt_q, t2_cnt_q;
	logic [7:0] n2_q, retry_q;
	logic [2:0] k_q, vs_q, vr_q;
	logic [23:0] frmr_info_q, frmr_sent_q;
	logic [16:0] tick_cnt_q;
	logic t1_run_q, busy_q, win_full_q;
	logic [31:0] rdata_q;

	// ------------------------------------------------------------------
	// Receive decode
	// ------------------------------------------------------------------
	// Bad address lengths are dropped here so no state reacts to them
	wire addr_ok = (rx_frame.addr_octets == `AXLR_ADDR_OCT_SHORT) ||
		(rx_frame.addr_octets == `AXLR_ADDR_OCT_LONG);
	wire rx_ok = rx_frame.valid && rx_frame.fcs_ok && addr_ok;
	wire rx_c = rx_ok && rx_frame.is_cmd;
	wire rx_r = rx_ok && !rx_frame.is_cmd;
	wire rx_sabm = rx_c && (rx_frame.kind == K_SABM);
	wire rx_disc = rx_c && (rx_frame.kind == K_DISC);
	wire rx_ua = rx_r && (rx_frame.kind == K_UA);
	wire rx_dm = rx_r && (rx_frame.kind == K_DM);
	wire rx_frmr = rx_r && (rx_frame.kind == K_FRMR);
	wire rx_other_cmd = rx_c && !rx_sabm && !rx_disc;
	wire rx_poll_odd = rx_other_cmd && rx_frame.pf &&
		(rx_frame.kind != K_UI);
	wire rx_bad = rx_ok && ((rx_frame.kind == K_UNK) ||
		(rx_frame.info_len > `AXLR_N1_MAX));
	wire rx_fin = rx_r && rx_frame.pf && ua_reset_q;

	// ------------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------------
	wire wr_ctrl = reg_wr && (reg_addr == `AXLR_OFS_CTRL);
	wire wr_t1 = reg_wr && (reg_addr == `AXLR_OFS_T1);
	wire wr_t2 = reg_wr && (reg_addr == `AXLR_OFS_T2);
	wire wr_n2 = reg_wr && (reg_addr == `AXLR_OFS_N2);
	wire wr_win = reg_wr && (reg_addr == `AXLR_OFS_WIN);
	wire wr_frmr = reg_wr && (reg_addr == `AXLR_OFS_FRMR);
	wire req_conn = wr_ctrl && reg_wdata[`AXLR_CTRL_CONNECT];
	wire req_disc = wr_ctrl && reg_wdata[`AXLR_CTRL_DISC];
	wire req_dm = wr_ctrl && reg_wdata[`AXLR_CTRL_DM];
	wire req_frmr = wr_ctrl && reg_wdata[`AXLR_CTRL_FRMR];
	wire req_reset = wr_ctrl && reg_wdata[`AXLR_CTRL_RESET];
	wire req_recover = wr_ctrl && reg_wdata[`AXLR_CTRL_RECOVER];
	wire [31:0] stat_word = {4'h0, retry_q, 7'h00, busy_q, 1'b0, vr_q,
		1'b0, vs_q, t1_run_q, st_q};
	wire [31:0] rd_mux =
		(reg_addr == `AXLR_OFS_CTRL) ? {30'h0, ua_reset_q, accept_q} :
		(reg_addr == `AXLR_OFS_T1) ? {16'h0000, t1_q} :
		(reg_addr == `AXLR_OFS_T2) ? {16'h0000, t2_q} :
		(reg_addr == `AXLR_OFS_N2) ? {24'h000000, n2_q} :
		(reg_addr == `AXLR_OFS_WIN) ? {29'h0, k_q} :
		(reg_addr == `AXLR_OFS_FRMR) ? {8'h00, frmr_info_q} :
		(reg_addr == `AXLR_OFS_STAT) ? stat_word : 32'h00000000;

	// ------------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------------
	wire tx_sent = tx_valid_q && tx_ready;
	wire tick = (tick_cnt_q == 17'(TICK_CYCLES - 1));
	wire t1_start = tx_sent && need_t1_q;
	wire t1_exp = t1_run_q && tick && (t1_cnt_q <= 16'h0001);
	// T2 only in transfer and only while T1 is idle
	wire t2_on = (st_q == S_INFO) && !t1_run_q;
	wire t2_exp = t2_on && tick && (t2_cnt_q <= 16'h0001);
	wire last_try = ({1'b0, retry_q} + 9'h001) >= {1'b0, n2_q};
	wire t1_stop = (st_d == S_DISC) || (st_d == S_INFO) ||
		(st_d == S_DMOUT);

	// ------------------------------------------------------------------
	// Protocol state machine; received frames beat T1 (bar the last FRMR retry), T1 beats software, software beats T2
	// ------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		q_en = 1'b0;
		q_t1 = 1'b0;
		q_frame = '{kind: K_RR, is_cmd: 1'b0, pf: 1'b0, info: 24'h000000};
		r_clr = 1'b0;
		r_inc = 1'b0;
		seq_zero = 1'b0;
		case (st_q)
			S_DISC, S_DMRETRY: begin
				if (rx_sabm && accept_q) begin
					q_en = 1'b1;
					q_frame.kind = K_UA;
					q_frame.pf = rx_frame.pf;
					st_d = S_INFO;
					seq_zero = 1'b1;
				end else if (rx_sabm || rx_disc || rx_poll_odd) begin
					q_en = 1'b1;
					q_frame.kind = K_DM;
					q_frame.pf = rx_frame.pf;
					st_d = S_DISC;
				end else if (st_q == S_DMRETRY && t1_exp) begin
					// Silent once the last DM has had its T1
					if (last_try) begin
						st_d = S_DISC;
					end else begin
						q_en = 1'b1;
						q_t1 = 1'b1;
						q_frame.kind = K_DM;
						r_inc = 1'b1;
					end
				end else if (req_conn) begin
					q_en = 1'b1;
					q_t1 = 1'b1;
					q_frame.kind = K_SABM;
					q_frame.is_cmd = 1'b1;
					q_frame.pf = 1'b1;
					r_clr = 1'b1;
					st_d = S_SETUP;
				end else if (req_recover) begin
					q_en = 1'b1;
					q_t1 = 1'b1;
					q_frame.kind = K_DM;
					r_clr = 1'b1;
					st_d = S_DMRETRY;
				end
			end
			S_SETUP: begin
				if (rx_ua) begin
					st_d = S_INFO;
					seq_zero = 1'b1;
				end else if (rx_dm) begin
					st_d = S_DISC;
				end else if (rx_sabm) begin
					q_en = 1'b1;
					q_frame.kind = K_UA;
					q_frame.pf = rx_frame.pf;
					st_d = S_INFO;
					seq_zero = 1'b1;
				end else if (rx_disc) begin
					q_en = 1'b1;
					q_frame.kind = K_DM;
					st_d = S_DISC;
				end else if (t1_exp) begin
					if (last_try) begin
						st_d = S_DISC;
					end else begin
						q_en = 1'b1;
						q_t1 = 1'b1;
						q_frame.kind = K_SABM;
						q_frame.is_cmd = 1'b1;
						q_frame.pf = 1'b1;
						r_inc = 1'b1;
					end
				end
			end
			S_DISCRQ: begin
				if (rx_ua || rx_dm) begin
					st_d = S_DISC;
				end else if (rx_disc) begin
					q_en = 1'b1;
					q_frame.kind = K_UA;
					q_frame.pf = rx_frame.pf;
					st_d = S_DISC;
				end else if (rx_sabm) begin
					q_en = 1'b1;
					q_frame.kind = K_DM;
					st_d = S_DISC;
				end else if (t1_exp) begin
					if (last_try) begin
						st_d = S_DISC;
					end else begin
						q_en = 1'b1;
						q_t1 = 1'b1;
						q_frame.kind = K_DISC;
						q_frame.is_cmd = 1'b1;
						q_frame.pf = 1'b1;
						r_inc = 1'b1;
					end
				end
			end
			S_INFO: begin
				if (rx_disc) begin
					q_en = 1'b1;
					q_frame.kind = K_UA;
					q_frame.pf = rx_frame.pf;
					st_d = S_DISC;
				end else if (rx_sabm) begin
					q_en = 1'b1;
					q_frame.kind = K_UA;
					q_frame.pf = rx_frame.pf;
					seq_zero = 1'b1;
				end else if (rx_dm || rx_frmr || rx_bad ||
					(rx_ua && ua_reset_q) ||
					rx_fin || req_reset) begin
					q_en = 1'b1;
					q_t1 = 1'b1;
					q_frame.kind = K_SABM;
					q_frame.is_cmd = 1'b1;
					q_frame.pf = 1'b1;
					r_clr = 1'b1;
					st_d = S_SETUP;
				end else if (req_disc) begin
					q_en = 1'b1;
					q_t1 = 1'b1;
					q_frame.kind = K_DISC;
					q_frame.is_cmd = 1'b1;
					q_frame.pf = 1'b1;
					r_clr = 1'b1;
					st_d = S_DISCRQ;
				end else if (req_dm) begin
					q_en = 1'b1;
					q_frame.kind = K_DM;
					st_d = S_DMOUT;
				end else if (req_frmr) begin
					q_en = 1'b1;
					q_t1 = 1'b1;
					q_frame.kind = K_FRMR;
					q_frame.info = frmr_info_q;
					r_clr = 1'b1;
					st_d = S_FRMR;
				end else if (t2_exp) begin
					q_en = 1'b1;
					q_frame.kind = K_RR;
					q_frame.is_cmd = 1'b1;
					q_frame.pf = 1'b1;
				end
			end
			S_DMOUT: begin
				// Disconnected only once the DM has really left
				if (tx_sent) begin
					st_d = S_DISC;
				end
			end
			S_FRMR: begin
				if (rx_sabm) begin
					q_en = 1'b1;
					q_frame.kind = K_UA;
					q_frame.pf = rx_frame.pf;
					st_d = S_INFO;
					seq_zero = 1'b1;
				end else if (rx_disc) begin
					q_en = 1'b1;
					q_frame.kind = K_UA;
					q_frame.pf = rx_frame.pf;
					st_d = S_DISC;
				end else if (rx_dm) begin
					st_d = S_DISC;
				end else if (t1_exp && last_try) begin
					q_en = 1'b1;
					q_t1 = 1'b1;
					q_frame.kind = K_SABM;
					q_frame.is_cmd = 1'b1;
					q_frame.pf = 1'b1;
					r_clr = 1'b1;
					st_d = S_SETUP;
				end else if (rx_other_cmd || t1_exp) begin
					q_en = 1'b1;
					q_t1 = 1'b1;
					q_frame.kind = K_FRMR;
					q_frame.info = frmr_sent_q;
					r_inc = t1_exp;
				end
			end
			default: begin
				st_d = S_DISC;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Frame request slot; a newer request replaces an unsent one
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_valid_q <= 1'b0;
			need_t1_q <= 1'b0;
			tx_q <= '{kind: K_RR, is_cmd: 1'b0, pf: 1'b0, info: 24'h000000};
		end else if (q_en) begin
			tx_valid_q <= 1'b1;
			need_t1_q <= q_t1;
			tx_q <= q_frame;
		end else if (tx_sent) begin
			tx_valid_q <= 1'b0;
		end
	end

	// State, retry count and saved reject information
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= S_DISC;
			retry_q <= 8'h00;
			frmr_sent_q <= 24'h000000;
		end else begin
			st_q <= st_d;
			retry_q <= r_clr ? 8'h00 : r_inc ? retry_q + 8'h01 : retry_q;
			if (q_en && q_frame.kind == K_FRMR && st_q == S_INFO)
				frmr_sent_q <= q_frame.info;
		end
	end

	// T1 restarts on each timed frame that leaves; T2 reloads when idle
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tick_cnt_q <= 17'h00000;
			t1_run_q <= 1'b0;
			t1_cnt_q <= 16'h0000;
			t2_cnt_q <= 16'h0000;
		end else begin
			tick_cnt_q <= tick ? 17'h00000 : tick_cnt_q + 17'h00001;
			if (t1_start) begin
				t1_run_q <= 1'b1;
				t1_cnt_q <= t1_q;
			end else if (t1_exp || t1_stop) begin
				t1_run_q <= 1'b0;
			end else if (tick) begin
				t1_cnt_q <= t1_cnt_q - 16'h0001;
			end
			if (!t2_on || t2_exp)
				t2_cnt_q <= t2_q;
			else if (tick)
				t2_cnt_q <= t2_cnt_q - 16'h0001;
		end
	end

	// Sequence variables wrap at eight; a busy set wins over its clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			vs_q <= 3'h0;
			vr_q <= 3'h0;
			busy_q <= 1'b0;
			win_full_q <= 1'b0;
		end else begin
			vs_q <= seq_zero ? 3'h0 : vs_q + {2'h0, seq_send_inc};
			vr_q <= seq_zero ? 3'h0 : vr_q + {2'h0, seq_recv_inc};
			busy_q <= busy_set || (busy_q && !busy_clr && !seq_zero);
			win_full_q <= (3'(vs_q - ack_nr)) >= k_q;
		end
	end

	// ------------------------------------------------------------------
	// Registers and read port
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			accept_q <= 1'b0;
			ua_reset_q <= 1'b0;
			t1_q <= `AXLR_T1_RST;
			t2_q <= `AXLR_T2_RST;
			n2_q <= `AXLR_N2_RST;
			k_q <= `AXLR_K_RST;
			frmr_info_q <= 24'h000000;
			rdata_q <= 32'h00000000;
		end else begin
			if (wr_ctrl) begin
				accept_q <= reg_wdata[`AXLR_CTRL_ACCEPT];
				ua_reset_q <= reg_wdata[`AXLR_CTRL_UA_RESET];
			end
			// Zero would stop the timers, so the floor is one tick
			if (wr_t1)
				t1_q <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 :
					reg_wdata[15:0];
			if (wr_t2)
				t2_q <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 :
					reg_wdata[15:0];
			if (wr_n2)
				n2_q <= (reg_wdata[7:0] == 8'h00) ? 8'h01 :
					reg_wdata[7:0];
			if (wr_win)
				k_q <= (reg_wdata[2:0] == 3'h0) ? 3'h1 : reg_wdata[2:0];
			if (wr_frmr)
				frmr_info_q <= reg_wdata[23:0];
			rdata_q <= reg_rd ? rd_mux : 32'h00000000;
		end
	end

	// Outputs
	assign reg_rdata = rdata_q;
	assign tx_valid = tx_valid_q;
	assign tx_frame = tx_q;
	assign seq_send = vs_q;
	assign seq_recv = vr_q;
	assign local_busy = busy_q;
	assign window_full = win_full_q;
	assign link_up = (st_q == S_INFO);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence s_retry_out;
		(st_q == S_DISCRQ) && t1_exp && last_try && !rx_ok;
	endsequence
	sequence s_dm_leaves;
		(st_q == S_DMOUT) && tx_sent;
	endsequence
	property p_disc_giveup;
		@(posedge ref_clk) disable iff (sys_rst)
		s_retry_out |=> (st_q == S_DISC) && !t1_run_q;
	endproperty
	a_disc_giveup: assert property (p_disc_giveup)
		else $error("disconnect did not give up after retries");
	property p_disc_in_info;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_q == S_INFO) && rx_disc |=>
			tx_valid && (tx_frame.kind == K_UA) && (st_q == S_DISC);
	endproperty
	a_disc_in_info: assert property (p_disc_in_info)
		else $error("DISC while connected not answered with UA");
	property p_disc_idle;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_q == S_DISC) && rx_disc |=> tx_valid &&
			(tx_frame.kind == K_DM) && (tx_frame.pf == $past(rx_frame.pf));
	endproperty
	a_disc_idle: assert property (p_disc_idle)
		else $error("DISC while disconnected not answered with DM");
	property p_poll_dm;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_q == S_DISC) && rx_poll_odd && !rx_disc |=>
			tx_valid && (tx_frame.kind == K_DM) && tx_frame.pf;
	endproperty
	a_poll_dm: assert property (p_poll_dm)
		else $error("polled command not answered with DM final");
	property p_seq_zero;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_q == S_INFO) && rx_sabm |=> (vs_q == 3'h0) && (vr_q == 3'h0)
			&& !busy_q[*1] ##1 link_up;
	endproperty
	a_seq_zero: assert property (p_seq_zero)
		else $error("reset by SABM did not clear state variables");
	property p_dm_out;
		@(posedge ref_clk) disable iff (sys_rst)
		s_dm_leaves |=> (st_q == S_DISC) && !link_up;
	endproperty
	a_dm_out: assert property (p_dm_out)
		else $error("not disconnected after reset-request DM");
	property p_frmr_repeat;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_q == S_FRMR) && rx_other_cmd && !(t1_exp && last_try) |=>
			tx_valid && (tx_frame.kind == K_FRMR) &&
			(tx_frame.info == frmr_sent_q);
	endproperty
	a_frmr_repeat: assert property (p_frmr_repeat)
		else $error("FRMR repeat missing or info changed");
	property p_dm_resets;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_q == S_INFO) && (rx_dm || rx_frmr) && !rx_c |=>
			(st_q == S_SETUP) && (tx_frame.kind == K_SABM) && tx_frame.pf;
	endproperty
	a_dm_resets: assert property (p_dm_resets)
		else $error("DM or FRMR response did not start reset");
	property p_poll_bit;
		@(posedge ref_clk) disable iff (sys_rst)
		tx_valid && ((tx_frame.kind == K_SABM) || (tx_frame.kind == K_DISC))
			|-> tx_frame.pf && tx_frame.is_cmd;
	endproperty
	a_poll_bit: assert property (p_poll_bit)
		else $error("SABM or DISC sent without poll");
	property p_t2_idle;
		@(posedge ref_clk) disable iff (sys_rst)
		t2_exp && !rx_ok && !wr_ctrl |-> !t1_run_q ##1
			(tx_frame.kind == K_RR) && tx_frame.pf;
	endproperty
	a_t2_idle: assert property (p_t2_idle)
		else $error("T2 fired while T1 ran or sent no RR");
	property p_retry_inc;
		@(posedge ref_clk) disable iff (sys_rst)
		r_inc && !r_clr |=> retry_q == $past(retry_q) + 8'h01;
	endproperty
	a_retry_inc: assert property (p_retry_inc)
		else $error("retry count did not step on T1 retry");

endmodule
`default_nettype wire

// [core/axlr_params.svh]
// Constants for the packet link teardown and reset controller.
// Assumes inclusion by bare name from the package and the core module.
`ifndef AXLR_PARAMS_SVH
`define AXLR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------------
`define AXLR_OFS_CTRL 8'h00
`define AXLR_OFS_T1 8'h04
`define AXLR_OFS_T2 8'h08
`define AXLR_OFS_N2 8'h0C
`define AXLR_OFS_WIN 8'h10
`define AXLR_OFS_FRMR 8'h14
`define AXLR_OFS_STAT 8'h18

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define AXLR_CTRL_ACCEPT 0
`define AXLR_CTRL_UA_RESET 1
`define AXLR_CTRL_CONNECT 8
`define AXLR_CTRL_DISC 9
`define AXLR_CTRL_DM 10
`define AXLR_CTRL_FRMR 11
`define AXLR_CTRL_RESET 12
`define AXLR_CTRL_RECOVER 13

// ----------------------------------------------------------------------
// Reset values and protocol limits
// ----------------------------------------------------------------------
`define AXLR_T1_RST 16'h0BB8
`define AXLR_T2_RST 16'h2710
`define AXLR_N2_RST 8'h10
`define AXLR_K_RST 3'h7
`define AXLR_N1_MAX 10'h100
`define AXLR_FLAG 8'h7E
`define AXLR_ADDR_OCT_SHORT 5'h0E
`define AXLR_ADDR_OCT_LONG 5'h15

// ----------------------------------------------------------------------
// Timing: timers count ticks of one millisecond
// ----------------------------------------------------------------------
`define AXLR_CLK_NS 8
`define AXLR_TICK_NS 1000000

`endif

// [core/axlr_pkg.sv]
// Types shared by the link teardown and reset controller.
// Assumes axlr_params.svh is on the include path.
`include "axlr_params.svh"

package axlr_pkg;

	// ------------------------------------------------------------------
	// Frame kinds seen or produced at the link layer
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		K_I, K_RR, K_RNR, K_REJ, K_SABM, K_DISC, K_DM, K_UA, K_FRMR,
		K_UI, K_UNK
	} axlr_kind_type;

	// Controller states
	typedef enum logic [2:0] {
		S_DISC, S_DMRETRY, S_SETUP, S_DISCRQ, S_INFO, S_DMOUT, S_FRMR
	} axlr_state_type;

	// Decoded received frame, one-cycle valid from the deframer
	typedef struct packed {
		logic valid;
		axlr_kind_type kind;
		logic is_cmd;
		logic pf;
		logic fcs_ok;
		logic [4:0] addr_octets;
		logic [9:0] info_len;
	} axlr_rx_type;

	// Frame request to the framer
	typedef struct packed {
		axlr_kind_type kind;
		logic is_cmd;
		logic pf;
		logic [23:0] info;
	} axlr_tx_type;

endpackage

// [verif/axlr_remote.sv]
// Far station stand-in: takes frame requests after random stalls.
// Assumes the link controller runs on the same clock.
`timescale 1ns/100ps
`default_nettype none
module axlr_remote (
	// Clock
	input wire logic ref_clk,
	// Framer handshake
	input wire logic tx_valid,
	output var logic tx_ready
);
	integer seed = 36;
	int stall = 0;
	initial tx_ready = 1'b0;
	// Stall 0..3 cycles so both prompt and slow takes occur
	always @(posedge ref_clk) begin
		tx_ready <= 1'b0;
		if (tx_valid && !tx_ready) begin
			if (stall == 0) begin
				tx_ready <= 1'b1;
				stall = $unsigned($random(seed)) % 4;
			end else
				stall = stall - 1;
		end
	end
endmodule
`default_nettype wire

// [verif/tb_ax25_link_teardown_reset.sv]
// Bench for the link teardown and reset controller.
// Assumes axlr_remote as framer and a four-cycle timer tick.
`timescale 1ns/100ps
`default_nettype none
module tb_ax25_link_teardown_reset;
	import axlr_pkg::*;
	localparam logic [29:0] ALL = 30'h3FFFFFFF;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic s_inc = 1'b0;
	logic b_set = 1'b0;
	logic rd_p = 1'b0;
	logic [31:0] reg_rdata;
	logic [2:0] vs, vr;
	logic bsy, wf, lup;
	logic tx_valid;
	logic tx_ready;
	axlr_tx_type tx_frame;
	axlr_rx_type rx_frame = '0;
	logic [63:0] txq[$];
	logic [63:0] rdq[$];
	integer seed = 36;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;

	initial forever #4 ref_clk = ~ref_clk;

	axlr_link_ctrl #(.TICK_CYCLES(4)) dut (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_frame(rx_frame), .tx_valid(tx_valid), .tx_frame(tx_frame),
		.tx_ready(tx_ready), .seq_send_inc(s_inc), .seq_recv_inc(s_inc),
		.ack_nr(3'h0), .busy_set(b_set), .busy_clr(1'b0), .seq_send(vs),
		.seq_recv(vr), .local_busy(bsy), .window_full(wf), .link_up(lup));
	axlr_remote rem (.ref_clk(ref_clk), .tx_valid(tx_valid),
		.tx_ready(tx_ready));

	task automatic results();
		if (txq.size() != 0)
			bad_count++;
		if (bad_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Mask zero marks an empty queue, so a surprise result fails
	task automatic chk(input logic [63:0] e, input logic [31:0] got);
		n_checks++;
		if (e[63:32] == 32'h0 || (got & e[63:32]) !== e[31:0]) begin
			bad_count++;
			$display("wrong value at %0t: got %h", $time, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, v);
		rdq.push_back({m, v});
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic ex(input axlr_kind_type k, input logic c, p,
		input logic [23:0] i, input logic [29:0] m);
		txq.push_back({2'b0, m, 2'b0, k, c, p, i});
	endtask
	// One checked frame; address length picked at random
	task automatic rx(input axlr_kind_type k, input logic c, p);
		logic [4:0] a;
		a = ($random(seed) & 1) ? 5'h15 : 5'h0E;
		rx_frame <= '{1'b1, k, c, p, 1'b1, a, 10'h000};
		@(posedge ref_clk);
		rx_frame <= '0;
		@(posedge ref_clk);
	endtask
	task automatic flush();
		for (int n = 0; n < 300 && txq.size() != 0; n++)
			@(posedge ref_clk);
	endtask
	task automatic up();
		ex(K_SABM, 1'b1, 1'b1, 24'h0, ALL);
		wr(8'h00, 32'h100);
		flush();
		rx(K_UA, 1'b0, 1'b1);
	endtask

	// Oldest note against each sent frame and read word
	always @(posedge ref_clk) begin
		rd_p <= reg_rd;
		cyc <= cyc + 1;
		if (tx_valid && tx_ready)
			chk(txq.size() == 0 ? 64'h0 : txq.pop_front(), {2'b0,
				tx_frame.kind, tx_frame.is_cmd, tx_frame.pf, tx_frame.info});
		if (rd_p)
			chk(rdq.size() == 0 ? 64'h0 : rdq.pop_front(), reg_rdata);
		if (cyc == 6000) begin
			bad_count++;
			results();
		end
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rd(8'h04, 32'hFFFF, 32'h0BB8);
		rd(8'h0C, 32'hFF, 32'h10);
		rd(8'h10, 32'h7, 32'h7);
		rd(8'h1C, 32'hFFFFFFFF, 32'h0);
		wr(8'h04, 32'd50);
		wr(8'h0C, 32'h3);
		ex(K_DM, 1'b0, 1'b1, 24'h0, ALL);
		rx(K_DISC, 1'b1, 1'b1);
		ex(K_DM, 1'b0, 1'b1, 24'h0, ALL);
		rx(K_RR, 1'b1, 1'b1);
		flush();
		up();
		ex(K_UA, 1'b0, 1'b1, 24'h0, ALL);
		rx(K_DISC, 1'b1, 1'b1);
		flush();
		rd(8'h18, 32'h7, 32'h0);
		up();
		// Two steps of both counts and busy, window of two, then peer reset
		wr(8'h10, 32'h2);
		s_inc <= 1'b1;
		b_set <= 1'b1;
		repeat (2) @(posedge ref_clk);
		s_inc <= 1'b0;
		b_set <= 1'b0;
		@(posedge ref_clk);
		rd(8'h18, 32'h1777, 32'h1224);
		chk({32'h1FF, 32'h1D2}, {23'h0, lup, wf, bsy, vr, vs});
		ex(K_UA, 1'b0, 1'b1, 24'h0, ALL);
		rx(K_SABM, 1'b1, 1'b1);
		flush();
		rd(8'h18, 32'h1777, 32'h4);
		chk({32'h1FF, 32'h100}, {23'h0, lup, wf, bsy, vr, vs});
		ex(K_SABM, 1'b1, 1'b1, 24'h0, ALL);
		rx(K_DM, 1'b0, 1'b0);
		flush();
		rx(K_UA, 1'b0, 1'b1);
		wr(8'h14, 32'hA5C3E1);
		ex(K_FRMR, 1'b0, 1'b0, 24'hA5C3E1, 30'h3EFFFFFF);
		wr(8'h00, 32'h800);
		flush();
		// Repeat on a command, then one more when T1 runs out
		repeat (2) ex(K_FRMR, 1'b0, 1'b0, 24'hA5C3E1, 30'h3EFFFFFF);
		rx(K_RR, 1'b1, 1'b0);
		flush();
		ex(K_UA, 1'b0, 1'b0, 24'h0, 30'h3E000000);
		rx(K_SABM, 1'b1, 1'b1);
		flush();
		// Optional reset on UA, then an unknown frame; both restart setup
		wr(8'h00, 32'h2);
		ex(K_SABM, 1'b1, 1'b1, 24'h0, ALL);
		rx(K_UA, 1'b0, 1'b0);
		flush();
		rx(K_UA, 1'b0, 1'b1);
		ex(K_SABM, 1'b1, 1'b1, 24'h0, ALL);
		rx(K_UNK, 1'b1, 1'b0);
		flush();
		rx(K_UA, 1'b0, 1'b1);
		// Unanswered disconnect: three sends, then gives up
		wr(8'h04, 32'h1);
		repeat (3) ex(K_DISC, 1'b1, 1'b1, 24'h0, ALL);
		wr(8'h00, 32'h200);
		flush();
		repeat (40) @(posedge ref_clk);
		rd(8'h18, 32'h7, 32'h0);
		// Accepted setup, one keep-alive poll, then a DM reset request
		wr(8'h08, 32'h5);
		wr(8'h00, 32'h1);
		ex(K_UA, 1'b0, 1'b1, 24'h0, ALL);
		rx(K_SABM, 1'b1, 1'b1);
		ex(K_RR, 1'b1, 1'b1, 24'h0, ALL);
		ex(K_DM, 1'b0, 1'b0, 24'h0, ALL);
		repeat (28) @(posedge ref_clk);
		wr(8'h00, 32'h400);
		flush();
		// Recovery DM resent on T1 until N2 sends, then silence
		repeat (3) ex(K_DM, 1'b0, 1'b0, 24'h0, ALL);
		wr(8'h00, 32'h2000);
		flush();
		repeat (40) @(posedge ref_clk);
		rd(8'h18, 32'h7, 32'h0);
		results();
	end
endmodule
`default_nettype wire
